// *** design/board_control_pkg.sv ***
// Purpose: shared constants and types of the board control/status bank
// Assumes: 200 MHz board clock, byte-data transfers on the management bus
// Notes:   all timing counts are derived from the times named here

package board_control_pkg;

	// ------------------------------------------------------------------
	// clock and bus identity
	// ------------------------------------------------------------------
	localparam int unsigned CLOCK_HZ = 200_000_000;
	localparam logic [6:0] SMBUS_DEVICE_ADDR = 7'h2e;

	// ------------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_CONTROL_WRITE = 8'ha0;
	localparam logic [7:0] CMD_CONTROL_READ = 8'ha1;
	localparam logic [7:0] CMD_POWER_FAIL_CLEAR = 8'hb0;
	localparam logic [7:0] CMD_POWER_FAIL_READ = 8'hb1;
	localparam logic [7:0] CMD_WDG_RAIL_CLEAR = 8'hb2;
	localparam logic [7:0] CMD_WDG_RAIL_READ = 8'hb3;
	localparam logic [7:0] CMD_REVISION_READ = 8'hc1;

	// ------------------------------------------------------------------
	// reset and read values
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [1:0] STAT0_RESERVED = 2'h0;
	// arbitrary value
	localparam logic [7:0] LOGIC_REVISION_DEFAULT = 8'h01;
	localparam int unsigned POWER_FAIL_W = 6;
	localparam int unsigned RAIL_FAIL_W = 5;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int unsigned WDG_TICK_US = 1000;
	localparam int unsigned WDG_TICK_CYCLES =
		CLOCK_HZ / 1_000_000 * WDG_TICK_US;
	localparam int unsigned TICKS_PER_SEC = 1_000_000 / WDG_TICK_US;
	localparam int unsigned WDG_COUNT_W = 18;
	localparam int unsigned WDG_TIMEOUT_SEC_0 = 2;
	localparam int unsigned WDG_TIMEOUT_SEC_1 = 10;
	localparam int unsigned WDG_TIMEOUT_SEC_2 = 50;
	localparam int unsigned WDG_TIMEOUT_SEC_3 = 250;
	localparam int unsigned RESET_PULSE_NS = 1000;
	localparam int unsigned PULSE_W = 8;
	localparam logic [PULSE_W-1:0] RESET_PULSE_CYCLES =
		PULSE_W'((RESET_PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000);
	localparam int unsigned BLINK_HALF_MS = 250;
	localparam int unsigned BLINK_W = 9;
	localparam logic [BLINK_W-1:0] BLINK_HALF_TICKS =
		BLINK_W'(BLINK_HALF_MS * 1000 / WDG_TICK_US);

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic green_led_on;
		logic handle_switch_disable;
		logic handle_switch_reset_select;
		logic timeout_select_first;
		logic timeout_select_second;
		logic watchdog_retrigger;
		logic red_led_blink;
		logic full_system_reset;
	} board_control_t;

	typedef struct packed {
		logic watchdog_armed_flag;
		logic watchdog_reset_flag;
		logic watchdog_half_time_flag;
		logic [RAIL_FAIL_W-1:0] rail_fail;
	} watchdog_rail_status_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK,
		ST_IGNORE
	} smbus_state_t;

endpackage : board_control_pkg

// *** design/pin_sync.sv ***
// Purpose: two-flop synchroniser for a group of pins
// Assumes: each bit is an independent level
// Notes:   first stage is read only by the second stage

`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RESET_VALUE = '0
) (
	input wire logic clock_i, // board clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic [W-1:0] async_i, // raw pins
	output logic [W-1:0] sync_o // synchronised levels
);

	logic [W-1:0] stage;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage <= RESET_VALUE;
			sync_o <= RESET_VALUE;
		end else begin
			stage <= async_i;
			sync_o <= stage;
		end
	end

endmodule : pin_sync

`default_nettype wire

// *** design/board_watchdog.sv ***
// Purpose: retriggerable watchdog with four selectable time-outs
// Assumes: retrigger is a single-cycle pulse from the bank; clear is held while the system reset pin is low and lasts one cycle on a bus or handle reset
// Notes:   counts in ticks so the long time-outs stay narrow

`timescale 1ns/100ps
`default_nettype none

module board_watchdog
	import board_control_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = WDG_TICK_CYCLES
) (
	input wire logic clock_i, // board clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic clear_i, // system reset: disarm
	input wire logic retrigger_i, // retrigger pulse
	input wire logic [1:0] select_i, // {second, first} select
	output logic tick_o, // one pulse per tick
	output logic armed_o, // watchdog armed
	output logic half_o, // half time elapsed
	output logic expire_o // time-out pulse
);

	localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	logic [PRE_W-1:0] prescale;
	logic [WDG_COUNT_W-1:0] count;
	wire logic [WDG_COUNT_W-1:0] limit;
	wire logic [WDG_COUNT_W-1:0] next_count;
	wire logic tick_now;

	assign limit = (select_i == 2'h0) ?
			WDG_COUNT_W'(WDG_TIMEOUT_SEC_0 * TICKS_PER_SEC) :
		(select_i == 2'h1) ? WDG_COUNT_W'(WDG_TIMEOUT_SEC_1 * TICKS_PER_SEC) :
		(select_i == 2'h2) ? WDG_COUNT_W'(WDG_TIMEOUT_SEC_2 * TICKS_PER_SEC) :
		WDG_COUNT_W'(WDG_TIMEOUT_SEC_3 * TICKS_PER_SEC);
	assign next_count = count + 1'b1;
	assign tick_now = (prescale == PRE_LAST);

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prescale <= '0;
			tick_o <= 1'b0;
		end else begin
			prescale <= tick_now ? '0 : prescale + 1'b1;
			tick_o <= tick_now;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count <= '0;
			armed_o <= 1'b0;
			half_o <= 1'b0;
			expire_o <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (clear_i) begin
				count <= '0;
				armed_o <= 1'b0;
				half_o <= 1'b0;
			end else if (retrigger_i) begin
				count <= '0;
				armed_o <= 1'b1;
				half_o <= 1'b0;
			end else if (armed_o && tick_o) begin
				if (next_count >= limit) begin
					count <= '0;
					armed_o <= 1'b0;
					half_o <= 1'b0;
					expire_o <= 1'b1;
				end else begin
					count <= next_count;
					if (next_count >= (limit >> 1))
						half_o <= 1'b1;
				end
			end
		end
	end

endmodule : board_watchdog

`default_nettype wire

// *** design/board_control_status_smbus.sv ***
// Purpose: management-bus slave bank for board control and status
// Assumes: rst_b_i is the board power-on reset; system resets arrive on a pin
// Notes:   sticky flags survive system resets; only rst_b_i and the clear commands clear them

`timescale 1ns/100ps
`default_nettype none

module board_control_status_smbus
	import board_control_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = WDG_TICK_CYCLES,
	parameter logic [7:0] LOGIC_REVISION = LOGIC_REVISION_DEFAULT
) (
	input wire logic clock_i, // 200 MHz board clock
	input wire logic rst_b_i, // power-on reset, active low
	input wire logic scl_i, // bus clock pin
	input wire logic sda_i, // bus data pin level
	output logic sda_o, // bus data drive value
	output logic sda_oe_b_o, // bus data enable, low drives
	input wire logic system_reset_b_i, // system reset pin, active low
	input wire logic handle_switch_i, // handle switch, high = actuated
	input wire logic [POWER_FAIL_W-1:0] power_fail_i, // regulator fails
	input wire logic [RAIL_FAIL_W-1:0] rail_fail_i, // supply rail fails
	output logic green_led_o, // green LED element
	output logic red_led_o, // red LED element
	output logic system_reset_o, // system reset request
	output logic power_event_o // power button event
);
	import board_control_pkg::*;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	localparam int unsigned PIN_W = 4 + POWER_FAIL_W + RAIL_FAIL_W;
	localparam logic [PIN_W-1:0] PIN_RESET =
		{3'h7, 1'b0, {POWER_FAIL_W{1'b0}}, {RAIL_FAIL_W{1'b0}}};

	wire logic [PIN_W-1:0] pins_s;
	wire logic scl_s;
	wire logic sda_s;
	wire logic sys_reset_b_s;
	wire logic handle_s;
	wire logic [POWER_FAIL_W-1:0] power_fail_s;
	wire logic [RAIL_FAIL_W-1:0] rail_fail_s;

	pin_sync #(
		.W(PIN_W),
		.RESET_VALUE(PIN_RESET)
	) u_pins (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.async_i({scl_i, sda_i, system_reset_b_i, handle_switch_i,
			power_fail_i, rail_fail_i}),
		.sync_o(pins_s)
	);

	assign {scl_s, sda_s, sys_reset_b_s, handle_s, power_fail_s,
		rail_fail_s} = pins_s;

	// ------------------------------------------------------------------
	// bus condition detection
	// ------------------------------------------------------------------
	logic scl_d;
	logic sda_d;
	logic handle_d;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			handle_d <= 1'b0;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			handle_d <= handle_s;
		end
	end

	wire logic scl_rise = scl_s & ~scl_d;
	wire logic scl_fall = ~scl_s & scl_d;
	// data edges while the clock stays high are start and stop
	wire logic start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire logic stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// ------------------------------------------------------------------
	// byte-data slave engine
	// ------------------------------------------------------------------
	smbus_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] command;
	logic rw;
	logic got_byte;
	logic master_nack;
	logic sda_low;
	logic wr_stb;
	logic [7:0] wr_data;
	wire logic [7:0] read_data;
	wire logic addr_match = (shift[7:1] == SMBUS_DEVICE_ADDR);
	wire logic receiving = (state == ST_ADDR) || (state == ST_CMD) ||
		(state == ST_WDATA);

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
			bit_cnt <= '0;
			shift <= '0;
			command <= '0;
			rw <= 1'b0;
			got_byte <= 1'b0;
			master_nack <= 1'b1;
			sda_low <= 1'b0;
			wr_stb <= 1'b0;
			wr_data <= '0;
		end else begin
			wr_stb <= 1'b0;
			if (start_det) begin
				// repeated start keeps the command for the read half
				state <= ST_ADDR;
				bit_cnt <= '0;
				got_byte <= 1'b0;
				sda_low <= 1'b0;
			end else if (stop_det) begin
				state <= ST_IDLE;
				sda_low <= 1'b0;
			end else if (scl_rise) begin
				if (receiving) begin
					shift <= {shift[6:0], sda_s};
					bit_cnt <= bit_cnt + 1'b1;
					got_byte <= (bit_cnt == 3'h7);
				end else if (state == ST_RDATA_ACK) begin
					master_nack <= sda_s;
				end
			end else if (scl_fall) begin
				case (state)
				ST_ADDR: begin
					if (got_byte) begin
						got_byte <= 1'b0;
						if (addr_match) begin
							sda_low <= 1'b1;
							rw <= shift[0];
							state <= ST_ADDR_ACK;
						end else begin
							state <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK: begin
					bit_cnt <= '0;
					if (rw) begin
						sda_low <= ~read_data[7];
						shift <= {read_data[6:0], 1'b0};
						state <= ST_RDATA;
					end else begin
						sda_low <= 1'b0;
						state <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (got_byte) begin
						got_byte <= 1'b0;
						command <= shift;
						sda_low <= 1'b1;
						state <= ST_CMD_ACK;
					end
				end
				ST_CMD_ACK: begin
					sda_low <= 1'b0;
					state <= ST_WDATA;
				end
				ST_WDATA: begin
					if (got_byte) begin
						got_byte <= 1'b0;
						wr_stb <= 1'b1;
						wr_data <= shift;
						sda_low <= 1'b1;
						state <= ST_WDATA_ACK;
					end
				end
				ST_WDATA_ACK: begin
					// only one data byte per write is taken
					sda_low <= 1'b0;
					state <= ST_IGNORE;
				end
				ST_RDATA: begin
					if (bit_cnt == 3'h7) begin
						sda_low <= 1'b0;
						state <= ST_RDATA_ACK;
					end else begin
						sda_low <= ~shift[7];
						shift <= {shift[6:0], 1'b0};
						bit_cnt <= bit_cnt + 1'b1;
					end
				end
				ST_RDATA_ACK: begin
					bit_cnt <= '0;
					if (!master_nack) begin
						sda_low <= ~read_data[7];
						shift <= {read_data[6:0], 1'b0};
						state <= ST_RDATA;
					end else begin
						state <= ST_IGNORE;
					end
				end
				default: begin
					sda_low <= 1'b0;
				end
				endcase
			end
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_b_o = ~sda_low;

	// ------------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------------
	board_control_t ctrl;
	logic [POWER_FAIL_W-1:0] power_fail_flags;
	logic watchdog_reset_flag;
	logic [RAIL_FAIL_W-1:0] rail_fail_flags;
	wire watchdog_rail_status_t wdg_status;
	wire logic wdg_armed;
	wire logic wdg_half;
	wire logic wdg_expire;
	wire logic tick;

	wire board_control_t wr_ctrl_val = board_control_t'(wr_data);
	wire logic wr_ctrl = wr_stb & (command == CMD_CONTROL_WRITE);
	wire logic clr_stat0 = wr_stb & (command == CMD_POWER_FAIL_CLEAR);
	wire logic clr_stat1 = wr_stb & (command == CMD_WDG_RAIL_CLEAR);
	wire logic retrigger = wr_ctrl &
		(wr_ctrl_val.watchdog_retrigger != ctrl.watchdog_retrigger);
	wire logic handle_press = handle_s & ~handle_d &
		~ctrl.handle_switch_disable;
	wire logic reset_start = (wr_ctrl & wr_ctrl_val.full_system_reset) |
		wdg_expire | (handle_press & ctrl.handle_switch_reset_select);
	wire logic power_start = handle_press &
		~ctrl.handle_switch_reset_select;
	// the system reset pin and our own request both count as system reset
	wire logic sys_clear = ~sys_reset_b_s | reset_start;

	assign wdg_status = '{
		watchdog_armed_flag: wdg_armed,
		watchdog_reset_flag: watchdog_reset_flag,
		watchdog_half_time_flag: wdg_half,
		rail_fail: rail_fail_flags
	};

	// reads of write-only or unknown codes answer zero
	assign read_data =
		(command == CMD_CONTROL_READ) ? ctrl :
		(command == CMD_POWER_FAIL_READ) ?
			{STAT0_RESERVED, power_fail_flags} :
		(command == CMD_WDG_RAIL_READ) ? wdg_status :
		(command == CMD_REVISION_READ) ? LOGIC_REVISION :
		UNMAPPED_READ;

	// ------------------------------------------------------------------
	// control and sticky status
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			ctrl <= CTRL_RESET;
		else if (sys_clear)
			ctrl <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl <= wr_ctrl_val;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_fail_flags <= '0;
			rail_fail_flags <= '0;
			watchdog_reset_flag <= 1'b0;
		end else begin
			power_fail_flags <= (clr_stat0 ? '0 : power_fail_flags) |
				power_fail_s;
			rail_fail_flags <= (clr_stat1 ? '0 : rail_fail_flags) |
				rail_fail_s;
			watchdog_reset_flag <= (clr_stat1 ? 1'b0 : watchdog_reset_flag) |
				wdg_expire;
		end
	end

	// ------------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------------
	board_watchdog #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_watchdog (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.clear_i(~sys_reset_b_s | (reset_start & ~wdg_expire)),
		.retrigger_i(retrigger),
		.select_i({ctrl.timeout_select_second,
			ctrl.timeout_select_first}),
		.tick_o(tick),
		.armed_o(wdg_armed),
		.half_o(wdg_half),
		.expire_o(wdg_expire)
	);

	// ------------------------------------------------------------------
	// output pulses and LEDs
	// ------------------------------------------------------------------
	logic [PULSE_W-1:0] reset_cnt;
	logic [PULSE_W-1:0] power_cnt;
	logic [BLINK_W-1:0] blink_cnt;
	logic blink_phase;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reset_cnt <= '0;
			system_reset_o <= 1'b0;
		end else if (reset_start) begin
			reset_cnt <= RESET_PULSE_CYCLES;
			system_reset_o <= 1'b1;
		end else if (reset_cnt != '0) begin
			reset_cnt <= reset_cnt - 1'b1;
			system_reset_o <= (reset_cnt != PULSE_W'(1));
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_cnt <= '0;
			power_event_o <= 1'b0;
		end else if (power_start) begin
			power_cnt <= RESET_PULSE_CYCLES;
			power_event_o <= 1'b1;
		end else if (power_cnt != '0) begin
			power_cnt <= power_cnt - 1'b1;
			power_event_o <= (power_cnt != PULSE_W'(1));
		end
	end

	// blink rides on the watchdog tick to avoid a second prescaler
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			blink_cnt <= '0;
			blink_phase <= 1'b0;
		end else if (tick) begin
			if (blink_cnt == BLINK_HALF_TICKS - 1'b1) begin
				blink_cnt <= '0;
				blink_phase <= ~blink_phase;
			end else begin
				blink_cnt <= blink_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			green_led_o <= 1'b0;
			red_led_o <= 1'b0;
		end else begin
			green_led_o <= ctrl.green_led_on;
			red_led_o <= ctrl.red_led_blink & blink_phase;
		end
	end

endmodule : board_control_status_smbus

`default_nettype wire

// *** verif/board_control_props.sv ***
// Purpose: port-level properties of the board control bank
// Assumes: one board clock domain, async active-low reset
// Notes:   pulse widths are measured by helper counters
`timescale 1ns/100ps
`default_nettype none
module board_control_props (
	input wire logic clock_i, // board clock
	input wire logic rst_b_i, // power-on reset
	input wire logic scl_i, // bus clock pin
	input wire logic sda_o, // data drive value
	input wire logic sda_oe_b_o, // data enable, low drives
	input wire logic system_reset_b_i, // system reset pin
	input wire logic handle_switch_i, // handle switch
	input wire logic green_led_o, // green element
	input wire logic red_led_o, // red element
	input wire logic system_reset_o, // reset request
	input wire logic power_event_o // power event
);
	import board_control_pkg::*;
	logic [7:0] rst_len;
	logic [7:0] evt_len;
	logic [3:0] hs_age;
	logic hs_d;
	// --------
	// helpers
	// --------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_len <= 8'h00;
			evt_len <= 8'h00;
			hs_age <= 4'hf;
			hs_d <= 1'b0;
		end else begin
			rst_len <= system_reset_o ? rst_len + 8'h01 : 8'h00;
			evt_len <= power_event_o ? evt_len + 8'h01 : 8'h00;
			hs_age <= (handle_switch_i && !hs_d) ? 4'h0 :
				hs_age + {3'h0, hs_age != 4'hf};
			hs_d <= handle_switch_i;
		end
	end
	// --------
	// properties
	// --------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence pin_drop;
		$fell(system_reset_b_i) ##1 !system_reset_b_i;
	endsequence
	a_sda_open_drain: assert property (sda_o == 1'b0)
		else $error("data drive value not low");
	a_sda_scl_low: assert property ($changed(sda_oe_b_o) |-> !scl_i)
		else $error("data changed with clock high");
	a_reset_width: assert property ($fell(system_reset_o)
		|-> rst_len == RESET_PULSE_CYCLES) else $error("reset width");
	a_event_width: assert property ($fell(power_event_o)
		|-> evt_len == RESET_PULSE_CYCLES) else $error("event width");
	a_one_action: assert property (!(system_reset_o && power_event_o))
		else $error("reset and event together");
	a_event_cause: assert property ($rose(power_event_o)
		|-> hs_age < 4'h8) else $error("event without switch");
	a_pin_green: assert property (pin_drop |-> ##[1:6] !green_led_o)
		else $error("green kept over system reset");
	a_pin_red: assert property (pin_drop |-> ##[1:6] !red_led_o)
		else $error("red kept over system reset");
	a_own_reset_led: assert property ($rose(system_reset_o)
		|-> ##[1:4] !green_led_o) else $error("control kept on reset");
endmodule : board_control_props
`default_nettype wire

// *** verif/smbus_host.sv ***
// Purpose: byte-data bus master in place of the hub controller
// Assumes: line resolved in the bench with a pull-up
// Notes:   clock idles high between frames, 125 ns per bit
`timescale 1ns/100ps
`default_nettype none
module smbus_host (
	input wire logic clock_i, // board clock
	input wire logic sda_i, // resolved data line
	output logic scl_o, // bus clock
	output logic sda_o // 0 pulls low, 1 releases
);
	import board_control_pkg::*;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask : wt
	// data moves mid-low, sampled mid-high
	task automatic slot(input logic b, output logic r);
		wt(6);
		sda_o <= b;
		wt(7);
		scl_o <= 1'b1;
		wt(6);
		r = sda_i;
		wt(6);
		scl_o <= 1'b0;
	endtask : slot
	// start is (1,0,0), stop is (0,1,1)
	task automatic edge_of(input logic a, input logic b, input logic s);
		wt(6);
		sda_o <= a;
		wt(7);
		scl_o <= 1'b1;
		wt(12);
		sda_o <= b;
		wt(12);
		scl_o <= s;
	endtask : edge_of
	task automatic xfer(input logic [7:0] d, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			slot(d[i], r);
			q[i] = r;
		end
		slot(1'b1, r); // released: device ack, or our nack on reads
		ack = !r;
	endtask : xfer
	task automatic write_reg(input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k1;
		logic k2;
		logic k3;
		edge_of(1'b1, 1'b0, 1'b0);
		xfer({a, 1'b0}, q, k1);
		xfer(c, q, k2);
		xfer(d, q, k3);
		edge_of(1'b0, 1'b1, 1'b1);
		ok = k1 & k2 & k3;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] c, output logic [7:0] d);
		logic [7:0] q;
		logic k;
		edge_of(1'b1, 1'b0, 1'b0);
		xfer({SMBUS_DEVICE_ADDR, 1'b0}, q, k);
		xfer(c, q, k);
		edge_of(1'b1, 1'b0, 1'b0);
		xfer({SMBUS_DEVICE_ADDR, 1'b1}, q, k);
		xfer(8'hff, d, k);
		edge_of(1'b0, 1'b1, 1'b1);
	endtask : read_reg
endmodule : smbus_host
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: self-checking bench for the board control bank
// Assumes: tick of 10 cycles, so 2 s is 20000 cycles
// Notes:   bus traffic comes from the host model
`timescale 1ns/100ps
`default_nettype none
module tb;
	import board_control_pkg::*;
	localparam logic [7:0] REV = 8'h5a; // arbitrary
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic sys_b = 1'b1;
	logic handle = 1'b0;
	logic [5:0] pf = 6'h00;
	logic [4:0] rf = 5'h00;
	wire logic scl;
	wire logic sda_h;
	wire logic sda_dv;
	wire logic sda_oe_b;
	wire logic sda_line;
	logic green;
	logic red;
	logic sreset;
	logic pevent;
	int fail_count = 0;
	int comparisons = 0;
	always #2.5 clock_i = ~clock_i;
	assign sda_line = sda_h & (sda_oe_b | sda_dv);
	board_control_status_smbus #(.TICK_CYCLES(10), .LOGIC_REVISION(REV))
		uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl),
		.sda_i(sda_line), .sda_o(sda_dv), .sda_oe_b_o(sda_oe_b),
		.system_reset_b_i(sys_b), .handle_switch_i(handle),
		.power_fail_i(pf), .rail_fail_i(rf), .green_led_o(green),
		.red_led_o(red), .system_reset_o(sreset), .power_event_o(pevent));
	smbus_host host (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl),
		.sda_o(sda_h));
	// --------
	// helpers
	// --------
	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask : wt
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic ok;
		host.write_reg(SMBUS_DEVICE_ADDR, c, d, ok);
		chk({7'h00, ok}, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] d;
		host.read_reg(c, d);
		chk(d, e);
	endtask : rd
	// watch both action outputs over a window
	task automatic win(input int n, input logic [1:0] e);
		logic [1:0] s;
		s = 2'b00;
		repeat (n) begin
			@(posedge clock_i);
			s = s | {sreset, pevent};
		end
		chk({6'h00, s}, {6'h00, e});
	endtask : win
	task automatic push(input logic [1:0] e);
		handle <= 1'b1;
		win(300, e);
		handle <= 1'b0;
		wt(20);
	endtask : push
	// --------
	// scenarios
	// --------
	task automatic t_idle();
		logic ok;
		chk({6'h00, green, red}, 8'h00);
		rd(CMD_CONTROL_READ, CTRL_RESET);
		rd(CMD_WDG_RAIL_READ, 8'h00);
		host.write_reg(7'h2f, CMD_CONTROL_WRITE, 8'h80, ok);
		chk({7'h00, ok}, 8'h00);
		host.write_reg(SMBUS_DEVICE_ADDR, CMD_REVISION_READ, 8'hff, ok);
		rd(CMD_REVISION_READ, REV);
		rd(8'h33, UNMAPPED_READ);
		rd(CMD_CONTROL_READ, CTRL_RESET);
	endtask : t_idle
	task automatic t_leds();
		logic [1:0] seen;
		wr(CMD_CONTROL_WRITE, 8'h82);
		rd(CMD_CONTROL_READ, 8'h82);
		chk({7'h00, green}, 8'h01);
		seen = 2'b00;
		repeat (3000) begin
			@(posedge clock_i);
			seen = seen | {red, !red};
		end
		chk({6'h00, seen}, 8'h03);
	endtask : t_leds
	task automatic t_flags();
		pf <= 6'h2a;
		rf <= 5'h15;
		wt(10);
		pf <= 6'h00;
		rf <= 5'h00;
		rd(CMD_POWER_FAIL_READ, 8'h2a);
		rd(CMD_WDG_RAIL_READ, 8'h15);
		sys_b <= 1'b0;
		wt(20);
		sys_b <= 1'b1;
		wt(10);
		chk({6'h00, green, red}, 8'h00);
		rd(CMD_CONTROL_READ, CTRL_RESET);
		rd(CMD_POWER_FAIL_READ, 8'h2a);
		rd(CMD_WDG_RAIL_READ, 8'h15);
		wr(CMD_POWER_FAIL_CLEAR, 8'h5a);
		rd(CMD_POWER_FAIL_READ, 8'h00);
		rd(CMD_WDG_RAIL_READ, 8'h15);
		wr(CMD_WDG_RAIL_CLEAR, 8'hff);
		rd(CMD_WDG_RAIL_READ, 8'h00);
	endtask : t_flags
	task automatic t_actions();
		wr(CMD_CONTROL_WRITE, 8'h00);
		push(2'b01);
		wr(CMD_CONTROL_WRITE, 8'h20);
		push(2'b10);
		wr(CMD_CONTROL_WRITE, 8'h40);
		push(2'b00);
		wr(CMD_CONTROL_WRITE, 8'h81);
		win(300, 2'b10);
		rd(CMD_CONTROL_READ, 8'h00);
	endtask : t_actions
	task automatic t_wdog();
		wr(CMD_CONTROL_WRITE, 8'h04);
		rd(CMD_WDG_RAIL_READ, 8'h80);
		win(10000, 2'b00);
		rd(CMD_WDG_RAIL_READ, 8'ha0);
		wr(CMD_CONTROL_WRITE, 8'h00);
		rd(CMD_WDG_RAIL_READ, 8'h80);
		win(17000, 2'b00);
		win(4000, 2'b10);
		rd(CMD_WDG_RAIL_READ, 8'h40);
		rd(CMD_CONTROL_READ, 8'h00);
		wr(CMD_CONTROL_WRITE, 8'h14);
		win(22000, 2'b00);
		rd(CMD_WDG_RAIL_READ, 8'hc0);
		sys_b <= 1'b0;
		wt(20);
		sys_b <= 1'b1;
		wt(10);
		rd(CMD_WDG_RAIL_READ, 8'h40);
		wr(CMD_CONTROL_WRITE, 8'h0c);
		rd(CMD_CONTROL_READ, 8'h0c);
		rd(CMD_WDG_RAIL_READ, 8'hc0);
	endtask : t_wdog
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	initial begin
		wt(10);
		rst_b_i <= 1'b1;
		wt(4);
		t_idle();
		t_leds();
		t_flags();
		t_actions();
		t_wdog();
		close_out();
	end
	initial begin
		wt(130000);
		fail_count++;
		$display("ERROR %0t: run did not finish", $time);
		close_out();
	end
endmodule : tb
bind board_control_status_smbus board_control_props props (.clock_i,
	.rst_b_i, .scl_i, .sda_o, .sda_oe_b_o, .system_reset_b_i,
	.handle_switch_i, .green_led_o, .red_led_o, .system_reset_o,
	.power_event_o);
`default_nettype wire
